// ### rtl/status_reporting_registers.sv
`timescale 1ns/1ns
`include "status_map.svh"

module status_reporting_registers
  import status_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire cmd_req_t   cmd_i,
  input  wire event_in_t  events_i,
  input  wire group_sum_t groups_i,
  input  wire logic       pending_i,
  output logic            cmd_ready_o,
  output resp_t           resp_o,
  output logic [7:0]      summary_byte_o,
  output logic            srq_o,
  output logic            clear_groups_o
);

  status_regs_t q;
  status_regs_t next_q;
  logic         opc_flag;
  logic         opc_query;
  logic         opc_busy;
  logic         take;
  logic         next_busy;
  logic [7:0]   evt_set;
  logic [7:0]   byte_now;

  // ---------------------------------------------------------------
  // Status byte assembly
  // ---------------------------------------------------------------
  // Bit 6 is left out of the OR so the summary cannot feed itself.
  function automatic logic [7:0] status_byte(input logic [7:0] esr,
                                             input logic [7:0] ese,
                                             input logic [7:0] sre,
                                             input group_sum_t g);
    logic [7:0] b;
    b                = `BYTE_ZERO;
    b[`STB_EQ_BIT]   = g.err_queue;
    b[`STB_QSUM_BIT] = g.quest_sum;
    b[`STB_MAV_BIT]  = g.msg_avail;
    b[`STB_ESB_BIT]  = |(esr & ese); // RL15
    b[`STB_MSS_BIT]  = |(b & sre); // RL16 RL17
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Completion waiter
  // ---------------------------------------------------------------
  opc_waiter u_opc (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .arm_flag_i   (take && cmd_i.code == cmd_opc),
    .arm_query_i  (take && cmd_i.code == cmd_opc_q),
    .pending_i    (pending_i),
    .done_flag_o  (opc_flag),
    .done_query_o (opc_query),
    .busy_o       (opc_busy)
  );

  // A command is taken only while ready stands, so the host and the block agree
  // on every edge. Ready stays low for one extra cycle after the waiter drains,
  // which keeps a new query from colliding with the completion reply.
  assign take      = cmd_i.valid && q.ready;
  assign next_busy = (take && cmd_i.code inside {cmd_opc, cmd_opc_q}) || opc_busy;
  assign byte_now  = status_byte(q.esr, q.ese, q.sre, groups_i);

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  // Bit 6 is only ever driven low, so it always reads zero.
  always_comb begin
    evt_set                  = `BYTE_ZERO;
    evt_set[`EVT_OPC_BIT]    = opc_flag; // RL14
    evt_set[`EVT_QERR_BIT]   = events_i.query_err;
    evt_set[`EVT_DERR_BIT]   = events_i.dev_err;
    evt_set[`EVT_EXEC_BIT]   = events_i.exec_err; // RL1
    evt_set[`EVT_CMD_BIT]    = events_i.cmd_err; // RL1
    evt_set[`EVT_UNUSED_BIT] = 1'b0; // RL1
  end

  // ---------------------------------------------------------------
  // Command execution
  // ---------------------------------------------------------------
  // An event arriving in the cycle of a clear survives it: the set is
  // merged after the clear. Responses stand for one cycle only.
  always_comb begin
    next_q            = q;
    next_q.resp.valid = 1'b0;
    next_q.cls        = 1'b0;
    if (take) begin
      unique case (cmd_i.code)
        cmd_cls: begin
          next_q.esr = `BYTE_ZERO; // RL3
          next_q.cls = 1'b1; // RL11
        end
        cmd_ese: next_q.ese = cmd_i.arg; // RL4 RL8
        cmd_sre: next_q.sre = cmd_i.arg; // RL5
        cmd_ese_q: begin
          next_q.resp = '{valid: 1'b1, data: q.ese}; // RL9
        end
        cmd_sre_q: begin
          next_q.resp = '{valid: 1'b1, data: q.sre}; // RL6
        end
        cmd_stb_q: begin
          next_q.resp = '{valid: 1'b1, data: byte_now}; // RL7
        end
        cmd_esr_q: begin
          next_q.resp = '{valid: 1'b1, data: q.esr}; // RL10
          next_q.esr  = `BYTE_ZERO; // RL3 RL2
        end
        default: ;
      endcase
    end
    if (opc_query) begin
      next_q.resp = '{valid: 1'b1, data: `OPC_REPLY}; // RL13
    end
    next_q.esr = next_q.esr | evt_set;
    next_q.stb = status_byte(next_q.esr, next_q.ese, next_q.sre, groups_i);
    next_q.srq = next_q.stb[`STB_MSS_BIT]; // RL17
    // Ready is low while an answer will stand or the waiter will be busy.
    next_q.ready = !next_q.resp.valid && !next_busy;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // The reset value marks power-on in the event register.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '{esr: `EVT_RESET, ese: `MASK_RESET, sre: `MASK_RESET, // RL2
             stb: `BYTE_ZERO, srq: 1'b0, resp: '{valid: 1'b0, data: `BYTE_ZERO},
             cls: 1'b0, ready: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // Ready is taken from the registered state so it has no path from inputs.
  assign cmd_ready_o    = q.ready;
  assign resp_o         = q.resp;
  assign summary_byte_o = q.stb;
  assign srq_o          = q.srq;
  assign clear_groups_o = q.cls;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The checks watch registered state and sampled inputs only. Back-to-back
  // commands are legal whenever ready stands, so none of them assumes a gap.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Event register: reserved bit, power-on marker, clearing and completion.
  chk_bit6_zero: assert property (q.esr[`EVT_UNUSED_BIT] == 1'b0) // RL1
    else $error("Unused event bit is set.");
  chk_pon_held: assert property ((q.esr[`EVT_PON_BIT] && !(take && cmd_i.code inside {cmd_cls, cmd_esr_q})) // RL2
                                 |=> q.esr[`EVT_PON_BIT])
    else $error("Power-on bit lost without a read.");
  chk_esr_read: assert property ((take && cmd_i.code == cmd_esr_q && evt_set == `BYTE_ZERO && !opc_query) // RL3 RL10
                                 |=> resp_o.valid && resp_o.data == $past(q.esr) && q.esr == `BYTE_ZERO)
    else $error("Event query did not answer and clear.");
  chk_esr_clear: assert property ((take && cmd_i.code == cmd_cls && evt_set == `BYTE_ZERO) // RL3
                                  |=> q.esr == `BYTE_ZERO)
    else $error("Clear left event bits set.");
  chk_opc_bit: assert property (opc_flag |=> q.esr[`EVT_OPC_BIT]) // RL12 RL14
    else $error("Completion bit not latched.");
  chk_opc_reply: assert property (opc_query |=> resp_o.valid && resp_o.data == `OPC_REPLY) // RL13
    else $error("Completion query reply wrong.");
  chk_opc_late: assert property ((opc_busy && pending_i) |=> !resp_o.valid) // RL13
    else $error("Completion reply came while work pending.");

  // Masks: a write replaces the whole mask and nothing else touches it.
  chk_ese_load: assert property ((take && cmd_i.code == cmd_ese) |=> q.ese == $past(cmd_i.arg)) // RL4 RL8
    else $error("Event enable not replaced.");
  chk_ese_keep: assert property (!(take && cmd_i.code == cmd_ese) |=> $stable(q.ese)) // RL4
    else $error("Event enable changed without a write.");
  chk_sre_load: assert property ((take && cmd_i.code == cmd_sre) |=> q.sre == $past(cmd_i.arg)) // RL5
    else $error("Request mask not loaded.");
  chk_sre_keep: assert property (!(take && cmd_i.code == cmd_sre) |=> $stable(q.sre)) // RL5
    else $error("Request mask changed without a write.");
  chk_ese_query: assert property ((take && cmd_i.code == cmd_ese_q) |=> resp_o.data == $past(q.ese)) // RL9
    else $error("Event enable query wrong.");
  chk_sre_echo: assert property ((take && cmd_i.code == cmd_sre_q) // RL6
                                 |=> resp_o.valid && resp_o.data == $past(q.sre))
    else $error("Request mask query wrong.");

  // Status byte: summaries are rebuilt every cycle from the registered state.
  chk_stb_query: assert property ((take && cmd_i.code == cmd_stb_q) // RL7
                                  |=> resp_o.valid && resp_o.data == $past(byte_now))
    else $error("Status query answer wrong.");
  chk_stb_keeps: assert property ((take && cmd_i.code == cmd_stb_q && q.srq && $stable(groups_i)) // RL7
                                  |=> srq_o)
    else $error("Status query cleared the summary flag.");
  chk_esb_sum: assert property (summary_byte_o[`STB_ESB_BIT] == |(q.esr & q.ese)) // RL15
    else $error("Event summary bit wrong.");
  chk_mss_sum: assert property (srq_o == |(summary_byte_o & q.sre & 8'hbf)) // RL16 RL17
    else $error("Master summary flag wrong.");
  chk_cls_pulse: assert property (clear_groups_o == $past(take && cmd_i.code == cmd_cls)) // RL11
    else $error("Group clear pulse wrong.");

  // Handshake: ready hides every cycle in which a command would be lost.
  chk_ready_resp: assert property (resp_o.valid |-> !cmd_ready_o)
    else $error("Ready raised while an answer stands.");
  chk_ready_busy: assert property (opc_busy |-> !cmd_ready_o)
    else $error("Ready raised while the waiter is busy.");
  chk_resp_single: assert property (resp_o.valid |=> !resp_o.valid)
    else $error("Answer stood for more than one cycle.");

  cov_esr_read: cover property (take && cmd_i.code == cmd_esr_q && q.esr[`EVT_PON_BIT]);
  cov_srq_up:   cover property (!srq_o ##1 srq_o);
  cov_opc_wait: cover property (opc_busy ##1 opc_busy ##1 opc_query);
  cov_set_clr:  cover property (take && cmd_i.code == cmd_cls && evt_set != `BYTE_ZERO);

endmodule // status_reporting_registers

// ### rtl/status_map.svh
// Function
// RL1: Event bits 4,5 flag errors; bit 6 zero.
// RL2: Event bit 7 marks reset since last read.
// RL3: Clear event register on clear or read query.
// RL4: Event enable write replaces the old mask.
// RL5: Request mask write loads eight bits, 0..255.
// RL6: Request mask query returns the current mask.
// RL7: Status query returns byte, summary flag kept.
// RL8: Event enable write loads eight bits, 0..255.
// RL9: Event enable query returns the enable mask.
// RL10: Event register query returns its contents.
// RL11: Clear wipes summaries and all event groups.
// RL12: Completion bit set once pending work finishes.
// RL13: Completion query answers 1 after pending work.
// RL14: Completion flag sits at event bit 0.
// RL15: Status bit 5 summarises enabled events.
// RL16: Status bit 6 summarises enabled summary bits.
// RL17: Summary flag ORs masked bits, drives request.
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// ---------------------------------------------------------------
// Event register bit positions
// ---------------------------------------------------------------
`define EVT_OPC_BIT    0
`define EVT_QERR_BIT   2
`define EVT_DERR_BIT   3
`define EVT_EXEC_BIT   4
`define EVT_CMD_BIT    5
`define EVT_UNUSED_BIT 6
`define EVT_PON_BIT    7

// ---------------------------------------------------------------
// Status byte bit positions
// ---------------------------------------------------------------
`define STB_EQ_BIT     2
`define STB_QSUM_BIT   3
`define STB_MAV_BIT    4
`define STB_ESB_BIT    5
`define STB_MSS_BIT    6

// ---------------------------------------------------------------
// Reset values and fixed answers
// ---------------------------------------------------------------
`define EVT_RESET      8'h80
`define MASK_RESET     8'h00
`define BYTE_ZERO      8'h00
`define OPC_REPLY      8'h01

`endif

// ### rtl/status_pkg.sv
package status_pkg;

  // Common command set accepted on the command port.
  typedef enum logic [3:0] {
    cmd_none,
    cmd_cls,
    cmd_ese,
    cmd_ese_q,
    cmd_esr_q,
    cmd_sre,
    cmd_sre_q,
    cmd_stb_q,
    cmd_opc,
    cmd_opc_q
  } cmd_code_t;

  typedef struct packed {
    logic      valid;
    cmd_code_t code;
    logic [7:0] arg;
  } cmd_req_t;

  // One-cycle event pulses from the command parser and executor.
  typedef struct packed {
    logic exec_err;
    logic cmd_err;
    logic query_err;
    logic dev_err;
  } event_in_t;

  // Summaries of the register groups kept outside this block.
  typedef struct packed {
    logic err_queue;
    logic quest_sum;
    logic msg_avail;
  } group_sum_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } resp_t;

  typedef enum logic [1:0] {
    opc_idle,
    opc_wait_flag,
    opc_wait_query
  } opc_state_t;

  typedef struct packed {
    opc_state_t st;
    logic       done_flag;
    logic       done_query;
    logic       busy;
  } opc_regs_t;

  typedef struct packed {
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] stb;
    logic       srq;
    resp_t      resp;
    logic       cls;
    logic       ready;
  } status_regs_t;

endpackage

// ### rtl/opc_waiter.sv
`timescale 1ns/1ns
`include "status_map.svh"

module opc_waiter
  import status_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic arm_flag_i,
  input  wire logic arm_query_i,
  input  wire logic pending_i,
  output logic      done_flag_o,
  output logic      done_query_o,
  output logic      busy_o
);

  opc_regs_t q;
  opc_regs_t next_q;

  // ---------------------------------------------------------------
  // Wait for pending operations to drain
  // ---------------------------------------------------------------
  // The waiter holds busy so no new command can overtake the pending reply.
  always_comb begin
    next_q            = q;
    next_q.done_flag  = 1'b0;
    next_q.done_query = 1'b0;
    unique case (q.st)
      opc_idle: begin
        if (arm_flag_i) begin
          next_q.st = opc_wait_flag;
        end else if (arm_query_i) begin
          next_q.st = opc_wait_query;
        end
      end
      opc_wait_flag: begin
        if (!pending_i) begin
          next_q.st        = opc_idle;
          next_q.done_flag = 1'b1; // RL12
        end
      end
      opc_wait_query: begin
        if (!pending_i) begin
          next_q.st         = opc_idle;
          next_q.done_query = 1'b1; // RL13
        end
      end
      default: next_q.st = opc_idle;
    endcase
    next_q.busy = (next_q.st != opc_idle);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '{st: opc_idle, done_flag: 1'b0, done_query: 1'b0, busy: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign done_flag_o  = q.done_flag;
  assign done_query_o = q.done_query;
  assign busy_o       = q.busy;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_flag_waits: assert property ((q.st == opc_wait_flag && pending_i) |=> !q.done_flag) // RL12
    else $error("Completion flag raised while work pending.");
  chk_query_done: assert property ((q.st == opc_wait_query && !pending_i) |=> q.done_query) // RL13
    else $error("Completion reply missing after work drained.");

endmodule // opc_waiter

// ### testbench/host_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Remote host model: sends one common command at a time
// ------------------------------------------------------------
module host_model
  import status_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  ready_i,
  input  wire resp_t resp_i,
  output cmd_req_t   cmd_o
);
  initial cmd_o = '{valid: 1'b0, code: cmd_none, arg: 8'h5a};

  // Holds the command until a rising edge sees ready high or 50 more rising edges pass, then releases it.
  // A released argument shows the inverse so a stale value is never mistaken for a live one.
  task automatic issue(input cmd_code_t c, input logic [7:0] a, input int wmax,
                       output logic got, output logic [7:0] data);
    int n;
    got  = 1'b0;
    data = 8'h00;
    n    = 0;
    @(negedge mclk_i);
    cmd_o = '{valid: 1'b1, code: c, arg: a};
    @(posedge mclk_i);
    while (ready_i !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    cmd_o = '{valid: 1'b0, code: cmd_none, arg: ~a};
    // The answer stands one cycle only, so it is looked at on every falling edge.
    for (n = 0; n < wmax && !got; n++) begin
      if (resp_i.valid === 1'b1) begin
        got  = 1'b1;
        data = resp_i.data;
      end else begin
        @(negedge mclk_i);
      end
    end
  endtask
endmodule // host_model

// ### testbench/status_reporting_registers_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end

module status_reporting_registers_tb;
  import status_pkg::*;
  logic       mclk_i, rst_n_i, pending_i, cmd_ready_o, srq_o, clear_groups_o, got;
  cmd_req_t   cmd_i;
  event_in_t  events_i;
  group_sum_t groups_i;
  resp_t      resp_o;
  logic [7:0] summary_byte_o, d;
  int         error_cnt = 0;
  int         n_tests   = 0;
  int         cycles    = 0;

  status_reporting_registers uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .events_i(events_i),
    .groups_i(groups_i), .pending_i(pending_i), .cmd_ready_o(cmd_ready_o), .resp_o(resp_o),
    .summary_byte_o(summary_byte_o), .srq_o(srq_o), .clear_groups_o(clear_groups_o));
  host_model host (.mclk_i(mclk_i), .ready_i(cmd_ready_o), .resp_i(resp_o), .cmd_o(cmd_i));

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // The whole run needs about 70 cycles, so 4000 leaves a wide margin.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic query(input cmd_code_t c, output logic [7:0] v);
    host.issue(c, 8'h00, 10, got, v);
    `CHK("answer present", 1'b1, got)
  endtask

  task automatic pulse(input logic [3:0] e);
    @(negedge mclk_i);
    events_i = event_in_t'(e);
    @(negedge mclk_i);
    events_i = '0;
    repeat (2) @(negedge mclk_i);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power_on();
    query(cmd_esr_q, d);
    `CHK("esr after reset", 8'h80, d)
    query(cmd_esr_q, d);
    `CHK("esr after read", 8'h00, d)
    $display("test power_on done");
  endtask

  task automatic t_events();
    pulse(4'b1100);
    query(cmd_esr_q, d);
    `CHK("esr errors", 8'h30, d)
    pulse(4'b0011);
    query(cmd_esr_q, d);
    `CHK("esr low errors", 8'h0c, d)
    $display("test events done");
  endtask

  task automatic t_masks();
    host.issue(cmd_ese, 8'h41, 0, got, d);
    host.issue(cmd_ese, 8'h20, 0, got, d);
    query(cmd_ese_q, d);
    `CHK("ese readback", 8'h20, d)
    pulse(4'b0100);
    `CHK("event summary", 1'b1, summary_byte_o[5])
    `CHK("srq masked", 1'b0, srq_o)
    host.issue(cmd_sre, 8'h20, 0, got, d);
    query(cmd_sre_q, d);
    `CHK("sre readback", 8'h20, d)
    repeat (2) @(negedge mclk_i);
    `CHK("master flag", 1'b1, summary_byte_o[6])
    `CHK("srq raised", 1'b1, srq_o)
    query(cmd_stb_q, d);
    `CHK("stb value", 8'h60, d)
    repeat (2) @(negedge mclk_i);
    `CHK("master kept", 1'b1, summary_byte_o[6])
    groups_i = 3'b111;
    repeat (3) @(negedge mclk_i);
    `CHK("group bits", 8'h7c, summary_byte_o)
    groups_i = '0;
    host.issue(cmd_cls, 8'h00, 0, got, d);
    `CHK("clear pulse", 1'b1, clear_groups_o)
    repeat (2) @(negedge mclk_i);
    `CHK("summary cleared", 8'h00, summary_byte_o)
    query(cmd_esr_q, d);
    `CHK("esr after clear", 8'h00, d)
    $display("test masks done");
  endtask

  task automatic t_opc();
    int i;
    pending_i = 1'b1;
    host.issue(cmd_opc, 8'h00, 0, got, d);
    repeat (4) @(negedge mclk_i);
    `CHK("busy while pending", 1'b0, cmd_ready_o)
    pending_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    query(cmd_esr_q, d);
    `CHK("completion bit", 8'h01, d)
    pending_i = 1'b1;
    host.issue(cmd_opc_q, 8'h00, 6, got, d);
    `CHK("early answer", 1'b0, got)
    pending_i = 1'b0;
    for (i = 0; i < 6 && resp_o.valid !== 1'b1; i++) @(negedge mclk_i);
    `CHK("opc answer valid", 1'b1, resp_o.valid)
    `CHK("opc answer", 8'h01, resp_o.data)
    $display("test opc done");
  endtask

  // Reset is held for three cycles; the first command is driven three falling edges after release.
  initial begin
    rst_n_i   = 1'b0;
    pending_i = 1'b0;
    events_i  = '0;
    groups_i  = '0;
    repeat (3) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_power_on();
    t_events();
    t_masks();
    t_opc();
    end_of_test();
  end
endmodule // status_reporting_registers_tb
